// *** verilog/smtc_pkg.sv ***
// constants, field layout and helpers for the serial-mode transfer control block
// assumes a 10 MHz register clock shared with the AXI4-Lite bus
package smtc_pkg;
    localparam int SMTC_ACLK_PERIOD_NS = 100;
    localparam int SMTC_SCLK_PERIOD_NS = 800;
    localparam int SMTC_HALF_CYCLES = SMTC_SCLK_PERIOD_NS / (2 * SMTC_ACLK_PERIOD_NS);
    localparam logic [4:0] SMTC_HALF = 5'(SMTC_HALF_CYCLES);

    localparam logic [7:0] SMTC_OFF_STATUS = 8'h0C;
    localparam logic [7:0] SMTC_OFF_BLOCK_LENGTH_COUNT = 8'h18;
    localparam logic [7:0] SMTC_OFF_DATA = 8'h28;
    localparam logic [7:0] SMTC_OFF_CFG = 8'h30;

    localparam logic [15:0] SMTC_CFG_RESET = 16'h0000;
    localparam logic [10:0] SMTC_BLOCK_LENGTH_COUNT_RESET = 11'h000;
    localparam logic [15:0] SMTC_DATA_RESET = 16'h0000;
    localparam int SMTC_STAT_FLAG_BIT = 0;
    localparam int SMTC_STAT_BUSY_BIT = 1;
    localparam int SMTC_CFG_LAUNCH_BIT = 15;

    localparam logic [4:0] SMTC_BYTE_BITS = 5'h08;
    localparam logic [4:0] SMTC_WORD_BITS = 5'h10;
    localparam logic [1:0] SMTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SMTC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic launch_transfer;
        logic count_on_transmit;
        logic serial_out_idle_value;
        logic per_write_trigger;
        logic [1:0] select_hold_delay;
        logic [1:0] select_setup_delay;
        logic connector_route;
        logic reserved6;
        logic [1:0] chip_select;
        logic manual_select_mode;
        logic select_force_high;
        logic clock_edge_offset;
        logic clock_idle_level;
    } smtc_cfg_t;

    typedef enum logic [1:0] {SMTC_IDLE, SMTC_SETUP, SMTC_SHIFT, SMTC_HOLD} smtc_state_t;

    // byte-lane merge of a 16-bit register image
    function automatic logic [15:0] smtc_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0] strb);
        smtc_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : smtc_merge

    // 1..4 serial periods, less the half period the shifter waits before its first edge
    function automatic logic [4:0] smtc_setup_cycles(input logic [1:0] code);
        smtc_setup_cycles = 5'((int'(code) + 1) * 2 * SMTC_HALF_CYCLES - SMTC_HALF_CYCLES);
    endfunction : smtc_setup_cycles

    // 0.5..3.5 serial clock periods
    function automatic logic [4:0] smtc_hold_cycles(input logic [1:0] code);
        smtc_hold_cycles = 5'((2 * int'(code) + 1) * SMTC_HALF_CYCLES);
    endfunction : smtc_hold_cycles
endpackage : smtc_pkg

// *** verilog/smtc_spi_mode_transfer_control.sv ***
// serial-mode master transfer control with an AXI4-Lite register slave
// assumes AXI master on aclk; serial-in pin is asynchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module smtc_spi_mode_transfer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_in,
    output var logic serial_out,
    output var logic dedicated_clk,
    output var logic [3:0] dedicated_select_n,
    output var logic card_clk,
    output var logic card_data3_out,
    output var logic card_data3_oe
);
    smtc_pkg::smtc_cfg_t cfg_reg;
    smtc_pkg::smtc_state_t st_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] aw_addr_reg;
    logic [15:0] wdata_reg;
    logic [1:0] wstrb_reg;
    logic [4:0] tmr_reg, edge_reg, nbits_reg;
    logic [15:0] tx_sh_reg, rx_sh_reg, rx_data_reg, tx_data_reg;
    logic [10:0] block_length_count_reg;
    logic so_reg, sclk_reg, cs_auto_reg, single_reg, flag_reg;
    logic si_meta_reg, si_sync_reg;
    logic dclk_reg, cclk_reg, d3_out_reg, d3_oe_reg;
    logic [3:0] dsel_reg;
    logic wr_fire, rd_fire, wr_cfg, wr_data, wr_block_length_count, mapped;
    logic start_blk, start_one, tmr_hit, out_ev, smp_ev, last_ev, more, tx_on, sel_low;
    logic [4:0] last_edge;
    logic [15:0] rx_next, load_word, load_tx;
    logic load_so;
    logic [3:0] cs_vec;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [15:0] block_length_count_merged;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign serial_out = so_reg;
    assign dedicated_clk = dclk_reg;
    assign dedicated_select_n = dsel_reg;
    assign card_clk = cclk_reg;
    assign card_data3_out = d3_out_reg;
    assign card_data3_oe = d3_oe_reg;

    // write: address and data taken independently, applied once both held
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_cfg = wr_fire && aw_addr_reg == smtc_pkg::SMTC_OFF_CFG;
    assign wr_data = wr_fire && aw_addr_reg == smtc_pkg::SMTC_OFF_DATA;
    assign wr_block_length_count = wr_fire && aw_addr_reg == smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT;
    assign mapped = aw_addr_reg == smtc_pkg::SMTC_OFF_CFG || aw_addr_reg == smtc_pkg::SMTC_OFF_DATA
                    || aw_addr_reg == smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT
                    || aw_addr_reg == smtc_pkg::SMTC_OFF_STATUS;
    assign start_blk = wr_cfg && wstrb_reg[1] && wdata_reg[smtc_pkg::SMTC_CFG_LAUNCH_BIT]
                       && !cfg_reg.per_write_trigger && st_reg == smtc_pkg::SMTC_IDLE;
    assign start_one = wr_data && cfg_reg.per_write_trigger
                       && st_reg == smtc_pkg::SMTC_IDLE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= smtc_pkg::SMTC_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            wstrb_reg <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_reg)
            begin
                aw_addr_reg <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end
            else if (bvalid_reg && s_axi_bready)
                awready_reg <= 1'b1;
            if (s_axi_wvalid && wready_reg)
            begin
                wdata_reg <= s_axi_wdata[15:0];
                wstrb_reg <= s_axi_wstrb[1:0];
                wready_reg <= 1'b0;
            end
            else if (bvalid_reg && s_axi_bready)
                wready_reg <= 1'b1;
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped ? smtc_pkg::SMTC_RESP_OKAY : smtc_pkg::SMTC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_reg <= smtc_pkg::SMTC_CFG_RESET;
        else if (wr_cfg)
        begin
            cfg_reg <= smtc_pkg::smtc_merge(cfg_reg, wdata_reg, wstrb_reg);
            cfg_reg.launch_transfer <= 1'b0;
            cfg_reg.reserved6 <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tx_data_reg <= smtc_pkg::SMTC_DATA_RESET;
        else if (wr_data)
            tx_data_reg <= smtc_pkg::smtc_merge(tx_data_reg, wdata_reg, wstrb_reg);
    end

    // read path: one-cycle answer, unmapped reads give zero and an error
    assign rd_fire = s_axi_arvalid && arready_reg;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            smtc_pkg::SMTC_OFF_CFG: rd_mux[15:0] = cfg_reg & 16'h7FBF;
            smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT: rd_mux[10:0] = block_length_count_reg;
            smtc_pkg::SMTC_OFF_DATA: rd_mux[15:0] = rx_data_reg;
            smtc_pkg::SMTC_OFF_STATUS:
            begin
                rd_mux[smtc_pkg::SMTC_STAT_FLAG_BIT] = flag_reg;
                rd_mux[smtc_pkg::SMTC_STAT_BUSY_BIT] = st_reg != smtc_pkg::SMTC_IDLE;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= smtc_pkg::SMTC_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? smtc_pkg::SMTC_RESP_OKAY : smtc_pkg::SMTC_RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // pin input crosses into aclk before the shifter looks at it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            si_meta_reg <= 1'b0;
            si_sync_reg <= 1'b0;
        end
        else
        begin
            si_meta_reg <= serial_in;
            si_sync_reg <= si_meta_reg;
        end
    end

    // shift engine timing; edges are half periods of SMTC_HALF cycles
    assign tmr_hit = tmr_reg == 5'h01;
    assign last_edge = 5'({nbits_reg, 1'b0} - 6'h01);
    assign out_ev = st_reg == smtc_pkg::SMTC_SHIFT && tmr_hit
                    && (edge_reg[0] != cfg_reg.clock_edge_offset);
    assign smp_ev = st_reg == smtc_pkg::SMTC_SHIFT && tmr_hit
                    && (edge_reg[0] == cfg_reg.clock_edge_offset);
    assign last_ev = st_reg == smtc_pkg::SMTC_SHIFT && tmr_hit && edge_reg == last_edge;
    assign rx_next = smp_ev ? {rx_sh_reg[14:0], si_sync_reg} : rx_sh_reg;
    assign block_length_count_merged = smtc_pkg::smtc_merge({5'h00, block_length_count_reg}, wdata_reg, wstrb_reg);
    assign more = !single_reg && block_length_count_reg > 11'h001;
    assign tx_on = cfg_reg.count_on_transmit || single_reg;
    // words are left-aligned so bit 15 always leaves first
    assign load_word = start_one ? (wstrb_reg[1] ? wdata_reg : {wdata_reg[7:0], 8'h00})
                                 : {tx_data_reg[7:0], 8'h00};
    assign load_tx = cfg_reg.clock_edge_offset ? load_word : {load_word[14:0], 1'b0};
    assign load_so = (!cfg_reg.clock_edge_offset && (cfg_reg.count_on_transmit || start_one))
                     ? load_word[15] : cfg_reg.serial_out_idle_value;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= smtc_pkg::SMTC_IDLE;
            tmr_reg <= 5'h00;
            edge_reg <= 5'h00;
            nbits_reg <= smtc_pkg::SMTC_BYTE_BITS;
            tx_sh_reg <= 16'h0000;
            rx_sh_reg <= 16'h0000;
            rx_data_reg <= smtc_pkg::SMTC_DATA_RESET;
            block_length_count_reg <= smtc_pkg::SMTC_BLOCK_LENGTH_COUNT_RESET;
            so_reg <= 1'b0;
            sclk_reg <= 1'b0;
            cs_auto_reg <= 1'b0;
            single_reg <= 1'b0;
        end
        else
        begin
            case (st_reg)
                smtc_pkg::SMTC_IDLE:
                begin
                    so_reg <= cfg_reg.serial_out_idle_value;
                    sclk_reg <= cfg_reg.clock_idle_level;
                    if (start_blk || start_one)
                    begin
                        st_reg <= smtc_pkg::SMTC_SETUP;
                        tmr_reg <= smtc_pkg::smtc_setup_cycles(cfg_reg.select_setup_delay);
                        cs_auto_reg <= 1'b1;
                        single_reg <= start_one;
                        nbits_reg <= (start_one && wstrb_reg[1]) ? smtc_pkg::SMTC_WORD_BITS
                                                                 : smtc_pkg::SMTC_BYTE_BITS;
                        edge_reg <= 5'h00;
                        tx_sh_reg <= load_tx;
                        so_reg <= load_so;
                    end
                end
                smtc_pkg::SMTC_SETUP:
                begin
                    tmr_reg <= tmr_reg - 5'h01;
                    if (tmr_hit)
                    begin
                        st_reg <= smtc_pkg::SMTC_SHIFT;
                        tmr_reg <= smtc_pkg::SMTC_HALF;
                    end
                end
                smtc_pkg::SMTC_SHIFT:
                begin
                    tmr_reg <= tmr_reg - 5'h01;
                    if (tmr_hit)
                    begin
                        tmr_reg <= smtc_pkg::SMTC_HALF;
                        sclk_reg <= ~sclk_reg;
                        edge_reg <= edge_reg + 5'h01;
                        rx_sh_reg <= rx_next;
                        if (out_ev)
                        begin
                            so_reg <= (last_ev || !tx_on) ? cfg_reg.serial_out_idle_value
                                                          : tx_sh_reg[15];
                            tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
                        end
                        if (last_ev)
                        begin
                            rx_data_reg <= (nbits_reg == smtc_pkg::SMTC_BYTE_BITS)
                                           ? {8'h00, rx_next[7:0]} : rx_next;
                            // rx and tx bytes finish together, so either count mode ticks here
                            if (!single_reg && block_length_count_reg != 11'h000)
                                block_length_count_reg <= block_length_count_reg - 11'h001;
                            if (more)
                            begin
                                edge_reg <= 5'h00;
                                tx_sh_reg <= load_tx;
                                so_reg <= load_so;
                            end
                            else
                            begin
                                st_reg <= smtc_pkg::SMTC_HOLD;
                                tmr_reg <= smtc_pkg::smtc_hold_cycles(cfg_reg.select_hold_delay);
                            end
                        end
                    end
                end
                smtc_pkg::SMTC_HOLD:
                begin
                    tmr_reg <= tmr_reg - 5'h01;
                    so_reg <= cfg_reg.serial_out_idle_value;
                    if (tmr_hit)
                    begin
                        st_reg <= smtc_pkg::SMTC_IDLE;
                        cs_auto_reg <= 1'b0;
                    end
                end
                default: st_reg <= smtc_pkg::SMTC_IDLE;
            endcase
            // count reloads only between transfers so a running block is not cut short
            if (wr_block_length_count && st_reg == smtc_pkg::SMTC_IDLE)
                block_length_count_reg <= block_length_count_merged[10:0];
        end
    end

    // set wins over the clear that a data read makes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_reg <= 1'b0;
        else if (last_ev)
            flag_reg <= 1'b1;
        else if (rd_fire && s_axi_araddr == smtc_pkg::SMTC_OFF_DATA)
            flag_reg <= 1'b0;
    end

    // select control; a forced-high transfer still clocks (dummy clocks)
    assign sel_low = !cfg_reg.select_force_high
                     && (cfg_reg.manual_select_mode || cs_auto_reg);
    assign cs_vec = ~(sel_low ? (4'h1 << cfg_reg.chip_select) : 4'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dclk_reg <= 1'b0;
            cclk_reg <= 1'b0;
            dsel_reg <= 4'hF;
            d3_out_reg <= 1'b1;
            d3_oe_reg <= 1'b0;
        end
        else
        begin
            dclk_reg <= cfg_reg.connector_route ? 1'b0 : sclk_reg;
            cclk_reg <= cfg_reg.connector_route ? sclk_reg : 1'b0;
            dsel_reg <= cfg_reg.connector_route ? (cs_vec | 4'h1) : cs_vec;
            d3_out_reg <= cs_vec[0];
            // released when unrouted so the external pull-up holds it high
            d3_oe_reg <= cfg_reg.connector_route;
        end
    end

    default clocking smtc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_LAUNCH_READS_ZERO: assert property (
        (rd_fire && s_axi_araddr == smtc_pkg::SMTC_OFF_CFG) |=> !s_axi_rdata[15])
        else $error("launch bit read back as one");
    AST_LAUNCH_BLOCKED: assert property (
        (wr_cfg && wdata_reg[15] && wstrb_reg[1] && cfg_reg.per_write_trigger
         && st_reg == smtc_pkg::SMTC_IDLE) |=> st_reg == smtc_pkg::SMTC_IDLE)
        else $error("launch not ignored under per-write trigger");
    AST_LAUNCH_RUNS: assert property (
        start_blk |=> (st_reg == smtc_pkg::SMTC_SETUP && cs_auto_reg))
        else $error("launch did not start a transfer");
    AST_SETUP_MIN: assert property (
        ($rose(st_reg == smtc_pkg::SMTC_SETUP) && cfg_reg.select_setup_delay == 2'h0)
        |-> (st_reg == smtc_pkg::SMTC_SETUP)[*4] ##1 st_reg == smtc_pkg::SMTC_SHIFT)
        else $error("setup delay not one serial period");
    AST_HOLD_MIN: assert property (
        ($rose(st_reg == smtc_pkg::SMTC_HOLD) && cfg_reg.select_hold_delay == 2'h0)
        |-> (st_reg == smtc_pkg::SMTC_HOLD)[*4] ##1 st_reg == smtc_pkg::SMTC_IDLE)
        else $error("hold delay not half a serial period");
    AST_FORCE_HIGH: assert property (
        (cfg_reg.select_force_high && !cfg_reg.connector_route && $stable(cfg_reg))
        |=> dedicated_select_n == 4'hF)
        else $error("select low while forced high");
    AST_OTHERS_HIGH: assert property (
        (!cfg_reg.connector_route && $stable(cfg_reg))
        |=> (dedicated_select_n | (4'h1 << $past(cfg_reg.chip_select))) == 4'hF)
        else $error("unselected select went low");
    AST_MANUAL_LOW: assert property (
        (cfg_reg.manual_select_mode && !cfg_reg.select_force_high && !cfg_reg.connector_route
         && $stable(cfg_reg))
        |=> dedicated_select_n == (4'hF ^ (4'h1 << $past(cfg_reg.chip_select))))
        else $error("manual select not low");
    AST_SO_IDLE: assert property (
        (st_reg == smtc_pkg::SMTC_IDLE && !start_blk && !start_one && $stable(cfg_reg))
        |=> serial_out == $past(cfg_reg.serial_out_idle_value))
        else $error("serial out not at idle value");
    AST_COUNT_DEC: assert property (
        (last_ev && !single_reg && block_length_count_reg != 11'h000 && !wr_block_length_count)
        |=> block_length_count_reg == $past(block_length_count_reg) - 11'h001)
        else $error("block count did not decrement");
    AST_STOP_ZERO: assert property (
        (last_ev && !single_reg && block_length_count_reg == 11'h001) |=> st_reg == smtc_pkg::SMTC_HOLD)
        else $error("transfer did not stop at zero");
    AST_FLAG_SET: assert property (
        last_ev |=> ##[0:1] flag_reg)
        else $error("completion flag not set");
    AST_ROUTE_UNUSED: assert property (
        (cfg_reg.connector_route && $stable(cfg_reg)) |=> (!dedicated_clk && dedicated_select_n[0]))
        else $error("unused dedicated pins not idle");

    COV_BLOCK: cover property (start_blk ##[1:400] last_ev && !more);
    COV_SINGLE_WORD: cover property (start_one && wstrb_reg[1] ##[1:400] last_ev);
    COV_DUMMY_CLOCKS: cover property (last_ev && cfg_reg.select_force_high);
    COV_ROUTED: cover property (last_ev && cfg_reg.connector_route);
endmodule : smtc_spi_mode_transfer_control
`default_nettype wire

// *** tb/smtc_card_model.sv ***
// card stand-in: mode 0 slave, msb first, same reply byte each frame
// assumes select and clock arrive as plain levels
`timescale 1ns/10ps
`default_nettype none
module smtc_card_model (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output var logic miso,
    output var logic [7:0] rx_byte
);
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(negedge sel_n) {miso, sh} = {tx_byte[7], tx_byte};
    always @(posedge sclk) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
    always @(negedge sclk) if (!sel_n) {miso, sh} = {sh[6], sh[6:0], 1'b0};
    // no pull on this line: invert so a stale bit never looks valid
    always @(posedge sel_n) miso = ~miso;
endmodule : smtc_card_model
`default_nettype wire

// *** tb/smtc_spi_mode_transfer_control_tb_top.sv ***
// bench: axi4-lite register tasks, pin monitor and a card model
// assumes the card answers on whichever select is low
`timescale 1ns/10ps
`default_nettype none
module smtc_spi_mode_transfer_control_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, card_rx;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'h0, dedicated_select_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
    logic serial_in, serial_out, dedicated_clk, card_clk, card_data3_out, card_data3_oe;
    logic dclk_q, cclk_q, sel_q;
    logic [4:0] low_seen;
    int mismatches = 0, n_tests = 0, n_d, n_c, cyc = 0, t_lo, t_e0, t_e1, t_hi;
    wire logic card_d3 = card_data3_oe ? card_data3_out : 1'b1; // pull-up
    wire logic sel_n = &dedicated_select_n & card_d3;
    smtc_spi_mode_transfer_control dut (.*);
    smtc_card_model card (.sclk(dedicated_clk | card_clk), .sel_n(sel_n), .mosi(serial_out),
        .tx_byte(8'h3C), .miso(serial_in), .rx_byte(card_rx));
    initial forever #50 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        {dclk_q, cclk_q, sel_q} <= {dedicated_clk, card_clk, sel_n};
        low_seen <= clr ? 5'h00 : low_seen | {~card_d3, ~dedicated_select_n};
        n_d <= clr ? 0 : n_d + int'(dclk_q != dedicated_clk);
        n_c <= clr ? 0 : n_c + int'(cclk_q != card_clk);
        if (sel_q && !sel_n) t_lo <= cyc;
        if (!sel_q && sel_n) t_hi <= cyc;
        if (dclk_q != dedicated_clk && n_d == 0) t_e0 <= cyc;
        if (dclk_q != dedicated_clk) t_e1 <= cyc;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        mismatches += int'(g !== e);
        if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        bresp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        {d, rresp_q} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask : expect_rd
    task automatic arm;
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
    endtask : arm
    // status polled, not timed: the engine latency is the design's business
    task automatic idle_wait;
        logic [31:0] st;
        st = 32'h2;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 300 && st[1] !== 1'b0; i++) rd(smtc_pkg::SMTC_OFF_STATUS, st);
        chk("engine idle", 32'h0, st & 32'h2);
        // pins and the monitor lag the engine by a few cycles
        repeat (3) @(posedge aclk);
    endtask : idle_wait
    task automatic go(input logic [15:0] c, input logic [4:0] el, input int ed, input int ec);
        wr(smtc_pkg::SMTC_OFF_CFG, c, 4'h3);
        // let an idle-level change reach the pins before counting edges
        repeat (3) @(posedge aclk);
        arm;
        wr(smtc_pkg::SMTC_OFF_CFG, c | 16'h8000, 4'h3);
        idle_wait;
        chk("select low", 32'(el), 32'(low_seen));
        chk("dedicated edges", ed, n_d);
        chk("card edges", ec, n_c);
    endtask : go
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        expect_rd(smtc_pkg::SMTC_OFF_CFG, 32'h0, "config");
        expect_rd(smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT, 32'h0, "count");
        expect_rd(8'h04, 32'h0, "unmapped");
        chk("unmapped resp", 32'(smtc_pkg::SMTC_RESP_SLVERR), 32'(rresp_q));
        wr(8'h04, 16'h0000, 4'h3);
        chk("unmapped wr resp", 32'(smtc_pkg::SMTC_RESP_SLVERR), 32'(bresp_q));
        wr(smtc_pkg::SMTC_OFF_DATA, 16'h00A5, 4'h3);
        chk("wr resp", 32'(smtc_pkg::SMTC_RESP_OKAY), 32'(bresp_q));
        for (int k = 0; k < 4; k++) go(16'h2000 | 16'(k << 4), 5'(1 << k), 16, 0);
        chk("card rx idle", 32'hFF, 32'(card_rx));
        expect_rd(smtc_pkg::SMTC_OFF_STATUS, 32'h1, "flag");
        expect_rd(smtc_pkg::SMTC_OFF_DATA, 32'h3C, "rx data");
        expect_rd(smtc_pkg::SMTC_OFF_CFG, 32'h2030, "launch bit");
        go(16'h2004, 5'h00, 16, 0);
        go(16'h2080, 5'h10, 0, 16);
        go(16'h0F03, 5'h01, 16, 0);
        chk("setup", 8 * smtc_pkg::SMTC_HALF_CYCLES, t_e0 - t_lo);
        chk("hold", 7 * smtc_pkg::SMTC_HALF_CYCLES, t_hi - t_e1);
        chk("clock idle", 32'h1, 32'(dedicated_clk));
        wr(smtc_pkg::SMTC_OFF_CFG, 16'h2008, 4'h3);
        repeat (3) @(posedge aclk);
        chk("manual low", 32'hE, 32'(dedicated_select_n));
        wr(smtc_pkg::SMTC_OFF_CFG, 16'h200C, 4'h3);
        repeat (3) @(posedge aclk);
        chk("manual high", 32'hF, 32'(dedicated_select_n));
        wr(smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT, 16'h0002, 4'h3);
        go(16'h6000, 5'h01, 32, 0);
        chk("card rx", 32'hA5, 32'(card_rx));
        expect_rd(smtc_pkg::SMTC_OFF_BLOCK_LENGTH_COUNT, 32'h0, "count left");
        rd(smtc_pkg::SMTC_OFF_DATA, v);
        go(16'h1000, 5'h00, 0, 0);
        for (int s = 3; s > 0; s -= 2)
        begin
            arm;
            wr(smtc_pkg::SMTC_OFF_DATA, 16'h1234, 4'(s));
            idle_wait;
            chk("word edges", 32'(8 + 8 * s), n_d);
            expect_rd(smtc_pkg::SMTC_OFF_STATUS, 32'h1, "done flag");
            rd(smtc_pkg::SMTC_OFF_DATA, v);
        end
        close_out;
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        mismatches++;
        close_out;
    end
endmodule : smtc_spi_mode_transfer_control_tb_top
`default_nettype wire
